// ==== core/mpr_byte_slot.sv ====
// Output holding stage of the data-in byte stream with valid and ready.
// Assumes i_load only while o_free is high.
module mpr_byte_slot #(
  parameter int WIDTH = 8
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_rst,
  input  wire logic             i_load,
  input  wire logic [WIDTH-1:0] i_byte,
  input  wire logic             i_ready,
  output logic                  o_valid,
  output logic [WIDTH-1:0]      o_byte,
  output logic                  o_free
);

  logic             vld_r;
  logic [WIDTH-1:0] byte_r;

  assign o_free  = !vld_r || i_ready;
  assign o_valid = vld_r;
  assign o_byte  = byte_r;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      vld_r <= 1'b0;
    end else if (i_load) begin
      vld_r <= 1'b1;
    end else if (i_ready) begin
      vld_r <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      byte_r <= '0;
    end else if (i_load) begin
      byte_r <= i_byte;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_slot_hold;
    @(posedge i_ref_clk) disable iff (i_rst)
    vld_r && !i_ready |=> vld_r && $stable(byte_r);
  endproperty
  a_slot_hold: assert property (p_slot_hold) else $error("held byte changed"); // [RULE17]

endmodule

// ==== core/mpr_page_rom.sv ====
// Table of supported pages: lookup by index, search by code, report length with header, block descriptor and all pages.
// Assumes combinational use by the report builder on the same clock.
`include "mpr_regs.svh"

module mpr_page_rom import mpr_pkg::*; (
  input  wire logic [3:0] i_idx,
  input  wire logic [5:0] i_code,
  output mpr_page_type    o_entry,
  output logic            o_hit,
  output logic [3:0]      o_hit_idx,
  output logic [7:0]      o_all_bytes
);

  localparam int NUM_PAGES = `MPR_NUM_PAGES;
  localparam mpr_page_type ROM [NUM_PAGES] = '{
    `MPR_PG_01, `MPR_PG_02, `MPR_PG_03, `MPR_PG_04, `MPR_PG_07, `MPR_PG_08, `MPR_PG_0A,
    `MPR_PG_0C, `MPR_PG_32, `MPR_PG_37, `MPR_PG_38, `MPR_PG_39, `MPR_PG_00};

  // ****************************************************************
  // Lookup and search
  // ****************************************************************
  always_comb begin
    o_entry     = (int'(i_idx) < NUM_PAGES) ? ROM[i_idx] : '0;
    o_hit       = 1'b0;
    o_hit_idx   = 4'h0;
    o_all_bytes = `MPR_HDR_BYTES + `MPR_BD_BYTES;
    // The trailing page is only reported inside the all-pages set
    for (int i = 0; i < NUM_PAGES - 1; i++) begin
      if (ROM[i].page_code == i_code) begin
        o_hit     = 1'b1;
        o_hit_idx = 4'(i);
      end
    end
    for (int i = 0; i < NUM_PAGES; i++) begin
      o_all_bytes = o_all_bytes + `MPR_PG_HDR_BYTES + ROM[i].page_len;
    end
  end

endmodule

// ==== core/mpr_pkg.sv ====
// Types of the mode parameter report builder.
// Assumes nothing of its surroundings.
package mpr_pkg;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    VSET_CURRENT    = 2'b00,
    VSET_CHANGEABLE = 2'b01,
    VSET_DEFAULT    = 2'b10,
    VSET_SAVED      = 2'b11
  } mpr_vset_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_HDR  = 3'b001,
    ST_BLK  = 3'b010,
    ST_PAGE = 3'b011,
    ST_END  = 3'b100
  } mpr_state_type;

  typedef struct packed {
    logic [1:0] page_control_select;
    logic [5:0] page_code;
    logic [7:0] alloc_len;
  } mpr_cmd_type;

  typedef struct packed {
    logic       parameters_saveable_flag;
    logic [5:0] page_code;
    logic [7:0] page_len;
  } mpr_page_type;

  typedef struct packed {
    mpr_vset_type value_set;
    logic [5:0]   page_code;
    logic [7:0]   index;
  } mpr_prm_req_type;

endpackage

// ==== core/mpr_regs.svh ====
// Constants of the mode parameter report builder: layout, fixed values, page set.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef MPR_REGS_SVH
`define MPR_REGS_SVH

// ****************************************************************
// Report layout
// ****************************************************************
`define MPR_HDR_BYTES     8'd4
`define MPR_BD_BYTES      8'd8
`define MPR_PG_HDR_BYTES  8'd2
`define MPR_HDR_LAST      8'd3
`define MPR_BD_LAST       8'd7

// ****************************************************************
// Header and block descriptor values
// ****************************************************************
`define MPR_MEDIUM_TYPE   8'h00
`define MPR_DEV_PARAM     8'h00
`define MPR_BD_LEN        8'h08
`define MPR_DENSITY       8'h00
`define MPR_BLOCK_COUNT   24'h000000
`define MPR_BD_RSVD       8'h00
`define MPR_BLOCK_LEN     24'h000200

// ****************************************************************
// Page set: {saveable, page code, page length}, report order
// ****************************************************************
`define MPR_NUM_PAGES     13
`define MPR_PAGE_ALL      6'h3F
`define MPR_PG_01         {1'b1, 6'h01, 8'h0A}
`define MPR_PG_02         {1'b1, 6'h02, 8'h0E}
`define MPR_PG_03         {1'b1, 6'h03, 8'h16}
`define MPR_PG_04         {1'b0, 6'h04, 8'h16}
`define MPR_PG_07         {1'b1, 6'h07, 8'h0A}
`define MPR_PG_08         {1'b1, 6'h08, 8'h12}
`define MPR_PG_0A         {1'b1, 6'h0A, 8'h06}
`define MPR_PG_0C         {1'b1, 6'h0C, 8'h16}
`define MPR_PG_32         {1'b1, 6'h32, 8'h06}
`define MPR_PG_37         {1'b1, 6'h37, 8'h0E}
`define MPR_PG_38         {1'b1, 6'h38, 8'h0E}
`define MPR_PG_39         {1'b1, 6'h39, 8'h0E}
`define MPR_PG_00         {1'b1, 6'h00, 8'h02}

`endif

// ==== core/mpr_report_builder.sv ====
// Mode parameter report builder: streams header, block descriptor and pages.
// Assumes command bytes, page parameter bytes and save events on the same clock.
//
// Function
// RULE1 - Page control selects current, changeable, default values
// RULE2 - Saved set falls back to defaults until saved
// RULE3 - Page length byte gives supported parameter count
// RULE4 - Initiator reuses reported page length when selecting
// RULE5 - Six-bit page code; twelve supported page codes
// RULE6 - All-pages code sends ascending, page zero last
// RULE7 - Stop at smaller of allocation and report length
// RULE8 - Four-byte header, block descriptor, then pages
// RULE9 - First byte is length excluding itself
// RULE10 - Medium type zero, write enabled, byte two zero
// RULE11 - Header byte three is eight
// RULE12 - Block descriptor layout, fields most significant first
// RULE13 - Block count reported as zero
// RULE14 - Block length reported as 512 bytes
// RULE15 - Page header: saveable, zero, code, length
// RULE16 - Saveable flag set only for storable pages
// RULE17 - Bytes strictly in order, most significant first
`include "mpr_regs.svh"

module mpr_report_builder import mpr_pkg::*; (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  input  wire logic        i_cmd_valid,
  input  wire mpr_cmd_type i_cmd,
  input  wire logic        i_save_commit,
  output logic             o_busy,
  output logic             o_cmd_error,
  output logic             o_done,
  output logic             o_din_valid,
  output logic [7:0]       o_din_byte,
  input  wire logic        i_din_ready,
  output mpr_prm_req_type  o_prm_req,
  input  wire logic [7:0]  i_prm_byte
);

  localparam logic [3:0] LAST_IDX = 4'(`MPR_NUM_PAGES - 1);

  mpr_state_type state_r;
  mpr_vset_type  vset_r;
  mpr_vset_type  vset_nxt;
  logic          all_r;
  logic          saved_r;
  logic          done_r;
  logic          err_r;
  logic [3:0]    idx_r;
  logic [3:0]    tbl_idx;
  logic [7:0]    fld_r;
  logic [7:0]    pos_r;
  logic [7:0]    limit_r;
  logic [7:0]    total_r;
  logic [7:0]    total_nxt;
  logic [7:0]    byte_nxt;
  logic [31:0]   hdr_w;
  logic [63:0]   bd_w;
  mpr_page_type  ent_w;
  logic          hit_w;
  logic [3:0]    hit_idx_w;
  logic [7:0]    all_bytes_w;
  logic          req_all_w;
  logic          accept_w;
  logic          slot_free_w;
  logic          adv_w;
  logic          load_w;
  logic          finish_w;
  logic          page_end_w;

  // ****************************************************************
  // Page table
  // ****************************************************************
  assign tbl_idx = (state_r == ST_IDLE) ? hit_idx_w : idx_r;
  mpr_page_rom u_rom (
    .i_idx       (tbl_idx),
    .i_code      (i_cmd.page_code),
    .o_entry     (ent_w),
    .o_hit       (hit_w),
    .o_hit_idx   (hit_idx_w),
    .o_all_bytes (all_bytes_w)
  );

  // ****************************************************************
  // Command decode
  // ****************************************************************
  assign accept_w  = i_cmd_valid && (state_r == ST_IDLE);
  assign req_all_w = (i_cmd.page_code == `MPR_PAGE_ALL); // [RULE6]

  always_comb begin
    vset_nxt = mpr_vset_type'(i_cmd.page_control_select); // [RULE1]
    if (vset_nxt == VSET_SAVED && !saved_r) begin
      vset_nxt = VSET_DEFAULT; // [RULE2]
    end
    total_nxt = req_all_w ? all_bytes_w
              : `MPR_HDR_BYTES + `MPR_BD_BYTES + `MPR_PG_HDR_BYTES + ent_w.page_len;
  end

  // Saved set exists once a select with save pages has completed
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      saved_r <= 1'b0;
    end else if (i_save_commit) begin
      saved_r <= 1'b1; // [RULE2]
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      vset_r  <= VSET_CURRENT;
      all_r   <= 1'b0;
      total_r <= 8'h00;
      limit_r <= 8'h00;
    end else if (accept_w) begin
      vset_r  <= vset_nxt;
      all_r   <= req_all_w;
      total_r <= total_nxt;
      // Any allocation length is legal; zero sends nothing
      limit_r <= (i_cmd.alloc_len < total_nxt) ? i_cmd.alloc_len : total_nxt; // [RULE7]
    end
  end

  // ****************************************************************
  // Byte generation
  // ****************************************************************
  assign hdr_w = {total_r - 8'h01, `MPR_MEDIUM_TYPE, // [RULE9] [RULE10]
                  `MPR_DEV_PARAM, `MPR_BD_LEN}; // [RULE10] [RULE11]
  assign bd_w  = {`MPR_DENSITY, `MPR_BLOCK_COUNT, // [RULE12] [RULE13]
                  `MPR_BD_RSVD, `MPR_BLOCK_LEN}; // [RULE12] [RULE14]

  always_comb begin
    byte_nxt = 8'h00;
    case (state_r)
      ST_HDR: begin
        byte_nxt = hdr_w[8'd31 - {fld_r[4:0], 3'b000} -: 8]; // [RULE17]
      end
      ST_BLK: begin
        byte_nxt = bd_w[8'd63 - {fld_r[4:0], 3'b000} -: 8]; // [RULE17]
      end
      ST_PAGE: begin
        if (fld_r == 8'h00) begin
          byte_nxt = {ent_w.parameters_saveable_flag, 1'b0, ent_w.page_code}; // [RULE15] [RULE16]
        end else if (fld_r == 8'h01) begin
          byte_nxt = ent_w.page_len; // [RULE3]
        end else begin
          byte_nxt = i_prm_byte;
        end
      end
      default: begin
        byte_nxt = 8'h00;
      end
    endcase
  end
  assign o_prm_req.value_set = vset_r;
  assign o_prm_req.page_code = ent_w.page_code;
  assign o_prm_req.index     = fld_r - `MPR_PG_HDR_BYTES;

  // ****************************************************************
  // Sequencing
  // ****************************************************************
  assign adv_w      = (state_r != ST_IDLE) && slot_free_w;
  assign load_w     = adv_w && (state_r != ST_END) && (pos_r < limit_r);
  assign finish_w   = adv_w && (pos_r >= limit_r);
  assign page_end_w = (fld_r == ent_w.page_len + 8'h01);

  mpr_byte_slot #(
    .WIDTH (8)
  ) u_slot (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_load    (load_w),
    .i_byte    (byte_nxt),
    .i_ready   (i_din_ready),
    .o_valid   (o_din_valid),
    .o_byte    (o_din_byte),
    .o_free    (slot_free_w)
  );

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      state_r <= ST_IDLE;
      idx_r   <= 4'h0;
      fld_r   <= 8'h00;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (accept_w && (req_all_w || hit_w)) begin // [RULE5]
            state_r <= ST_HDR;
            idx_r   <= req_all_w ? 4'h0 : hit_idx_w;
            fld_r   <= 8'h00;
          end
        end
        ST_HDR: begin
          if (finish_w) begin
            state_r <= ST_IDLE;
          end else if (load_w) begin
            fld_r   <= (fld_r == `MPR_HDR_LAST) ? 8'h00 : fld_r + 8'h01;
            state_r <= (fld_r == `MPR_HDR_LAST) ? ST_BLK : ST_HDR; // [RULE8]
          end
        end
        ST_BLK: begin
          if (finish_w) begin
            state_r <= ST_IDLE;
          end else if (load_w) begin
            fld_r   <= (fld_r == `MPR_BD_LAST) ? 8'h00 : fld_r + 8'h01;
            state_r <= (fld_r == `MPR_BD_LAST) ? ST_PAGE : ST_BLK; // [RULE8]
          end
        end
        ST_PAGE: begin
          if (finish_w) begin
            state_r <= ST_IDLE;
          end else if (load_w && page_end_w) begin
            fld_r <= 8'h00;
            if (all_r && idx_r != LAST_IDX) begin
              idx_r <= idx_r + 4'h1; // [RULE6]
            end else begin
              state_r <= ST_END;
            end
          end else if (load_w) begin
            fld_r <= fld_r + 8'h01;
          end
        end
        ST_END: begin
          if (finish_w) begin
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Counts bytes handed to the output stage
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      pos_r <= 8'h00;
    end else if (accept_w) begin
      pos_r <= 8'h00;
    end else if (load_w) begin
      pos_r <= pos_r + 8'h01; // [RULE7]
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      done_r <= 1'b0;
      err_r  <= 1'b0;
    end else begin
      done_r <= finish_w;
      err_r  <= accept_w && !req_all_w && !hit_w; // [RULE5]
    end
  end

  assign o_busy      = (state_r != ST_IDLE);
  assign o_done      = done_r;
  assign o_cmd_error = err_r;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  property p_first_len;
    load_w && pos_r == 8'h00 |=> o_din_byte == total_r - 8'h01;
  endproperty
  a_first_len: assert property (p_first_len) else $error("first byte not length"); // [RULE9]

  property p_hdr_zero;
    load_w && state_r == ST_HDR && (fld_r == 8'h01 || fld_r == 8'h02) |=> o_din_byte == 8'h00;
  endproperty
  a_hdr_zero: assert property (p_hdr_zero) else $error("header byte not zero"); // [RULE10]

  property p_bd_len;
    load_w && state_r == ST_HDR && fld_r == `MPR_HDR_LAST |=> o_din_byte == `MPR_BD_LEN;
  endproperty
  a_bd_len: assert property (p_bd_len) else $error("descriptor length wrong"); // [RULE11]

  property p_blk_zero;
    load_w && state_r == ST_BLK && fld_r < 8'h05 |=> o_din_byte == 8'h00;
  endproperty
  a_blk_zero: assert property (p_blk_zero) else $error("zero field wrong"); // [RULE12] [RULE13]

  property p_blk_len;
    load_w && state_r == ST_BLK && fld_r == 8'h06 |=> o_din_byte == 8'(`MPR_BLOCK_LEN >> 8);
  endproperty
  a_blk_len: assert property (p_blk_len) else $error("block length wrong"); // [RULE14]

  property p_done_count;
    o_done |-> pos_r == limit_r && !o_din_valid && !o_busy;
  endproperty
  a_done_count: assert property (p_done_count) else $error("transfer length wrong"); // [RULE7]

  property p_saved_fallback;
    accept_w && i_cmd.page_control_select == VSET_SAVED && !saved_r |=> vset_r == VSET_DEFAULT;
  endproperty
  a_saved_fallback: assert property (p_saved_fallback) else $error("saved fallback"); // [RULE2]

  property p_vset_pass;
    accept_w && !(i_cmd.page_control_select == VSET_SAVED && !saved_r)
      |=> vset_r == $past(i_cmd.page_control_select);
  endproperty
  a_vset_pass: assert property (p_vset_pass) else $error("value set wrong"); // [RULE1]

  property p_bad_page;
    accept_w && !req_all_w && !hit_w |=> o_cmd_error && !o_busy ##1 !o_din_valid;
  endproperty
  a_bad_page: assert property (p_bad_page) else $error("unsupported page sent"); // [RULE5]

  property p_page_hdr;
    load_w && state_r == ST_PAGE && fld_r == 8'h00
      |=> o_din_byte == {$past(ent_w.parameters_saveable_flag), 1'b0, $past(ent_w.page_code)};
  endproperty
  a_page_hdr: assert property (p_page_hdr) else $error("page header wrong"); // [RULE15] [RULE16]

  property p_page_len;
    load_w && state_r == ST_PAGE && fld_r == 8'h01 |=> o_din_byte == $past(ent_w.page_len);
  endproperty
  a_page_len: assert property (p_page_len) else $error("page length wrong"); // [RULE3]

  property p_order;
    $rose(state_r == ST_PAGE) |-> $past(state_r) == ST_BLK;
  endproperty
  a_order: assert property (p_order) else $error("section order wrong"); // [RULE8] [RULE17]

  property p_ascend;
    state_r == ST_PAGE && $past(state_r) == ST_PAGE && idx_r != $past(idx_r)
      |-> all_r && idx_r == $past(idx_r) + 4'h1;
  endproperty
  a_ascend: assert property (p_ascend) else $error("page order wrong"); // [RULE6]

  c_all_pages: cover property (state_r == ST_PAGE && all_r && idx_r == LAST_IDX ##[1:8] o_done);
  c_truncated: cover property (o_done && limit_r < total_r && limit_r != 8'h00);
  c_saved_use: cover property (accept_w && i_cmd.page_control_select == VSET_SAVED && saved_r);
  c_bad_page:  cover property (o_cmd_error);

endmodule

// ==== test/mpr_initiator_model.sv ====
// Far-side model: the bus initiator that takes data-in bytes, prompt or stalling.
// Assumes the builder's clock and its synchronous active-high reset.
module mpr_initiator_model (
  input  wire logic i_ref_clk,
  input  wire logic i_rst,
  input  wire logic i_slow,
  input  wire logic i_din_valid,
  output logic      o_din_ready
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [1:0] phase_r;

  // ****************************************************************
  // Stall pattern: in slow mode one acceptance in three cycles
  // ****************************************************************
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      phase_r <= 2'h0;
    end else begin
      phase_r <= (phase_r == 2'h2) ? 2'h0 : phase_r + 2'h1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_din_ready <= 1'b0;
    end else begin
      o_din_ready <= !i_slow || ((phase_r == 2'h0) && i_din_valid);
    end
  end
endmodule

// ==== test/mpr_report_builder_tb_top.sv ====
// Self-checking bench of the mode parameter report builder.
// Assumes the design package, constants header and initiator model are compiled.
`include "mpr_regs.svh"

module mpr_report_builder_tb_top import mpr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic            i_ref_clk;
  logic            i_rst;
  logic            i_cmd_valid;
  mpr_cmd_type     i_cmd;
  logic            i_save_commit;
  logic            i_din_ready;
  logic [7:0]      i_prm_byte;
  logic            o_busy;
  logic            o_cmd_error;
  logic            o_done;
  logic            o_din_valid;
  logic [7:0]      o_din_byte;
  mpr_prm_req_type o_prm_req;
  logic            slow;
  logic            saved;
  integer          seed;
  int              fail_count;
  int              checks_done;
  logic [7:0]      exp_q [$];
  mpr_page_type    pages [13] = '{`MPR_PG_01, `MPR_PG_02, `MPR_PG_03, `MPR_PG_04,
                                  `MPR_PG_07, `MPR_PG_08, `MPR_PG_0A, `MPR_PG_0C,
                                  `MPR_PG_32, `MPR_PG_37, `MPR_PG_38, `MPR_PG_39,
                                  `MPR_PG_00};
  logic [5:0]      codes [12] = '{6'h01, 6'h02, 6'h03, 6'h04, 6'h07, 6'h08,
                                  6'h0A, 6'h0C, 6'h32, 6'h37, 6'h38, 6'h39};
  logic [5:0]      bad [4] = '{6'h00, 6'h05, 6'h3E, 6'h3D};

  mpr_report_builder uut (
    .i_ref_clk     (i_ref_clk),
    .i_rst         (i_rst),
    .i_cmd_valid   (i_cmd_valid),
    .i_cmd         (i_cmd),
    .i_save_commit (i_save_commit),
    .o_busy        (o_busy),
    .o_cmd_error   (o_cmd_error),
    .o_done        (o_done),
    .o_din_valid   (o_din_valid),
    .o_din_byte    (o_din_byte),
    .i_din_ready   (i_din_ready),
    .o_prm_req     (o_prm_req),
    .i_prm_byte    (i_prm_byte)
  );

  mpr_initiator_model partner (
    .i_ref_clk   (i_ref_clk),
    .i_rst       (i_rst),
    .i_slow      (slow),
    .i_din_valid (o_din_valid),
    .o_din_ready (i_din_ready)
  );

  // ****************************************************************
  // Page store stand-in: byte value marks value set, page and index
  // ****************************************************************
  function automatic logic [7:0] prm_val(input logic [1:0] vs, input logic [5:0] code,
                                         input logic [7:0] idx);
    return {vs, code} ^ idx ^ 8'h5A;
  endfunction

  assign i_prm_byte = prm_val(o_prm_req.value_set, o_prm_req.page_code, o_prm_req.index);

  // ****************************************************************
  // Checking and closing
  // ****************************************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    checks_done++;
    if (seen !== want) begin
      fail_count++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, want);
    end
  endtask

  task automatic conclude();
    if (fail_count == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Expected report, cut to the allocation length, queued for the watcher
  task automatic build(input logic [1:0] pc, input logic [5:0] code, input logic [7:0] alloc);
    logic [7:0] rpt [$];
    logic [1:0] vs;
    int         n;
    vs = (pc == 2'b11 && !saved) ? 2'b10 : pc;
    rpt = '{8'h00, 8'h00, 8'h00, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00,
            8'h00, 8'h00, 8'h02, 8'h00};
    for (int p = 0; p < 13; p++) begin
      if ((code == 6'h3F) || (p < 12 && pages[p].page_code == code)) begin
        rpt.push_back({pages[p].parameters_saveable_flag, 1'b0, pages[p].page_code});
        rpt.push_back(pages[p].page_len);
        for (int i = 0; i < pages[p].page_len; i++) begin
          rpt.push_back(prm_val(vs, pages[p].page_code, 8'(i)));
        end
      end
    end
    rpt[0] = 8'(rpt.size() - 1);
    n = (alloc < rpt.size()) ? alloc : rpt.size();
    for (int i = 0; i < n; i++) begin
      exp_q.push_back(rpt[i]);
    end
  endtask

  task automatic run(input logic [1:0] pc, input logic [5:0] code, input logic [7:0] alloc,
                     input bit intrude);
    int k;
    build(pc, code, alloc);
    @(posedge i_ref_clk);
    i_cmd_valid <= 1'b1;
    i_cmd <= '{pc, code, alloc};
    @(posedge i_ref_clk);
    i_cmd_valid <= 1'b0;
    if (intrude) begin
      repeat (3) @(posedge i_ref_clk);
      i_cmd_valid <= 1'b1;
      i_cmd <= '{2'b00, 6'h01, 8'hFF};
      @(posedge i_ref_clk);
      i_cmd_valid <= 1'b0;
      #1;
      check(o_busy, 1'b1);
    end
    for (k = 0; k < 1000 && o_done !== 1'b1; k++) begin
      @(posedge i_ref_clk);
      #1;
    end
    check(16'(k < 1000), 16'h0001);
    check(16'(exp_q.size()), 16'h0000);
  endtask

  task automatic run_bad(input logic [5:0] code);
    @(posedge i_ref_clk);
    i_cmd_valid <= 1'b1;
    i_cmd <= '{2'b00, code, 8'hFF};
    @(posedge i_ref_clk);
    i_cmd_valid <= 1'b0;
    #1;
    check({o_cmd_error, o_busy, o_din_valid}, 16'h0004);
  endtask

  // ****************************************************************
  // Watcher: each accepted byte against the oldest expected byte
  // ****************************************************************
  always @(posedge i_ref_clk) begin
    if (!i_rst && o_din_valid === 1'b1 && i_din_ready === 1'b1) begin
      if (exp_q.size() == 0) begin
        check({8'hFF, o_din_byte}, 16'h0000);
      end else begin
        check(o_din_byte, exp_q.pop_front());
      end
    end
  end

  // ****************************************************************
  // Clock, watchdog and main sequence
  // ****************************************************************
  initial begin
    i_ref_clk = 1'b0;
    forever #4 i_ref_clk = ~i_ref_clk;
  end

  initial begin
    #(8 * 20000);
    fail_count++;
    conclude();
  end

  initial begin
    logic [31:0] r;
    i_rst = 1'b1;
    i_cmd_valid = 1'b0;
    i_cmd = '0;
    i_save_commit = 1'b0;
    slow = 1'b0;
    saved = 1'b0;
    seed = 32'h56D6;
    fail_count = 0;
    checks_done = 0;
    repeat (11) @(posedge i_ref_clk);
    #1;
    check({o_busy, o_done, o_cmd_error, o_din_valid, o_din_byte}, 16'h0000);
    @(posedge i_ref_clk);
    i_rst <= 1'b0;
    for (int pc = 0; pc < 4; pc++) begin
      run(2'(pc), 6'h3F, 8'hFF, pc == 0);
    end
    @(posedge i_ref_clk);
    i_save_commit <= 1'b1;
    @(posedge i_ref_clk);
    i_save_commit <= 1'b0;
    saved = 1'b1;
    run(2'b11, 6'h3F, 8'hFF, 1'b0);
    // Reset between runs forgets the saved set again
    @(posedge i_ref_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    saved = 1'b0;
    run(2'b11, 6'h0A, 8'hFF, 1'b0);
    slow <= 1'b1;
    run(2'b00, 6'h3F, 8'hC8, 1'b0);
    for (int i = 0; i < 12; i++) begin
      r = $random(seed);
      slow <= r[8];
      run(r[1:0], codes[i], r[23:16], 1'b0);
      run(r[3:2], codes[i], 8'hFF, 1'b0);
    end
    slow <= 1'b0;
    run(2'b00, 6'h01, 8'h00, 1'b0);
    run(2'b01, 6'h04, 8'h01, 1'b0);
    for (int i = 0; i < 4; i++) begin
      run_bad(bad[i]);
    end
    run(2'b10, 6'h0C, 8'h0F, 1'b0);
    conclude();
  end
endmodule
